//--- bench/dgr_spi_host.sv
`timescale 1ns/10ps
`default_nettype none
module dgr_spi_host (
    // Clock.
    input  wire logic clk_in,
    // Serial lines.
    output logic      cs_n_out,
    output logic      sclk_out,
    output logic      sdi_out,
    input  wire logic sdo_in
);
    // ========================================================
    // Host side frame driver, serial clock high for four system clocks and low for five.
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        sdi_out  = 1'b0;
    end
    task automatic xfer(input logic [23:0] frame, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clk_in) cs_n_out <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            @(posedge clk_in) sdi_out <= frame[i];
            repeat (3) @(posedge clk_in);
            @(negedge clk_in) if (i < 8) rd = {rd[6:0], sdo_in};
            @(posedge clk_in) sclk_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            sclk_out <= 1'b0;
        end
        repeat (4) @(posedge clk_in);
        cs_n_out <= 1'b1;
        sdi_out  <= ~sdi_out;
        repeat (6) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

//--- bench/test_dac_group_range_autodetect.sv
`timescale 1ns/10ps
`default_nettype none
module test_dac_group_range_autodetect;
    import dgr_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  below = 4'h5;
    logic        cs_n, sclk, sdi, sdo, oe_n, data_def, sdo_last;
    logic [7:0]  rng, rd;
    logic [3:0]  clamp_neg;
    logic [15:0] dac_clamp;
    wire logic   sdo_w;
    int          failures = 0;
    int          n_tests = 0;
    always #20 clk = ~clk;
    // A released data line shows the inverse of its last driven level.
    always @(posedge clk) if (!oe_n) sdo_last <= sdo;
    assign sdo_w = oe_n ? ~sdo_last : sdo;
    dgr_spi_host host_u (.clk_in(clk), .cs_n_out(cs_n), .sclk_out(sclk), .sdi_out(sdi), .sdo_in(sdo_w));
    dgr_range_ctrl dut_u (.CLK_IN(clk), .RST_IN(rst), .SPI_CS_N_IN(cs_n), .SPI_SCLK_IN(sclk),
        .SPI_SDI_IN(sdi), .SPI_SDO_OUT(sdo), .SPI_SDO_OE_N_OUT(oe_n), .GRP_BELOW_TH_IN(below),
        .GROUP_RANGE_OUT(rng), .CLAMP_NEG_OUT(clamp_neg), .DAC_CLAMP_OUT(dac_clamp),
        .DATA_DEFAULT_OUT(data_def));
    // ========================================================
    // Shared helpers.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.xfer({8'h00, a, d}, rd);
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic rdreg(input logic [7:0] a, input logic [7:0] exp);
        host_u.xfer({8'h80, a, 8'h00}, rd);
        chk({8'h00, rd}, {8'h00, exp});
    endtask
    task automatic set_below(input logic [3:0] b);
        @(posedge clk) below <= b;
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ========================================================
    // Scenarios.
    task automatic t_reset;
        repeat (9) @(posedge clk);
        @(negedge clk);
        chk({8'h00, rng}, 16'h0000);
        chk(dac_clamp, 16'hffff);
        chk({15'h0, data_def}, 16'h1);
        chk({15'h0, oe_n}, 16'h1);
        @(posedge clk) rst <= 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk({8'h00, rng}, 16'h0033);
        chk({12'h0, clamp_neg}, 16'h5);
        chk({15'h0, data_def}, 16'h0);
        rdreg(ADDR_STATUS, 8'h05);
    endtask
    task automatic t_host_range;
        wr(ADDR_RANGE_LO, 8'h09);
        wr(ADDR_RANGE_HI, 8'h0c);
        chk({8'h00, rng}, 16'h00c9);
        chk({12'h0, clamp_neg}, 16'h5);
        rdreg(ADDR_RANGE_LO, 8'h09);
        set_below(4'ha);
        chk({8'h00, rng}, 16'h00c9);
        chk({12'h0, clamp_neg}, 16'ha);
        rdreg(ADDR_STATUS, 8'h05);
    endtask
    task automatic redet(input logic [7:0] a, input logic [7:0] d, input logic [3:0] b, input logic [7:0] e);
        set_below(b);
        wr(a, d);
        chk({8'h00, rng}, {8'h00, e});
        rdreg(ADDR_STATUS, {4'h0, b});
    endtask
    task automatic t_refused;
        wr(ADDR_STATUS, 8'hff);
        rdreg(ADDR_STATUS, 8'h00);
        rdreg(8'h10, 8'h00);
        chk({8'h00, rng}, 16'h0000);
    endtask
    task automatic t_midreset;
        set_below(4'h5);
        @(posedge clk) rst <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(dac_clamp, 16'hffff);
        chk({15'h0, data_def}, 16'h1);
        @(posedge clk) rst <= 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk({8'h00, rng}, 16'h0033);
    endtask
    task automatic t_redetect;
        redet(ADDR_DEV_CFG, 8'h00, 4'ha, 8'hcc);
        redet(ADDR_PD_LO, 8'h0f, 4'hf, 8'hff);
        redet(ADDR_PD_HI, 8'h00, 4'h0, 8'h00);
        chk(dac_clamp, 16'h000f);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_sim();
    end
    initial begin
        t_reset();
        t_host_range();
        t_redetect();
        t_refused();
        t_midreset();
        end_sim();
    end
endmodule
`default_nettype wire

//--- logic/dgr_pkg.sv
package dgr_pkg;
    // ========================================================
    // Register offsets.
    localparam logic [7:0] ADDR_DEV_CFG   = 8'h02;
    localparam logic [7:0] ADDR_RANGE_LO  = 8'h1e;
    localparam logic [7:0] ADDR_RANGE_HI  = 8'h1f;
    localparam logic [7:0] ADDR_STATUS    = 8'h72;
    localparam logic [7:0] ADDR_PD_LO     = 8'hb2;
    localparam logic [7:0] ADDR_PD_HI     = 8'hb3;
    // ========================================================
    // Geometry and serial frame.
    localparam int         NUM_GROUPS     = 4;
    localparam int         NUM_DACS       = 16;
    localparam logic [4:0] FRAME_BITS     = 5'h18;
    localparam logic [4:0] HDR_BITS       = 5'h10;
    // ========================================================
    // Output range codes, two bits per group.
    localparam logic [1:0] RNG_POS5       = 2'h0;
    localparam logic [1:0] RNG_POS10      = 2'h1;
    localparam logic [1:0] RNG_NEG5       = 2'h2;
    localparam logic [1:0] RNG_NEG10      = 2'h3;
    // ========================================================
    // Reset values and detection settle count.
    localparam logic [7:0] CFG_RESET      = 8'h00;
    localparam logic [15:0] PD_RESET      = 16'hffff;
    localparam logic [7:0] RANGE_RESET    = 8'h00;
    localparam logic [1:0] DET_SETTLE     = 2'h3;
endpackage

//--- logic/dgr_range_ctrl.sv
// Notes on behaviour
// - Sixteen DACs form four groups of four sharing range and clamp level.
// - Each group's range and clamp settings are independent of other groups.
// - After reset every DAC output is held at its group clamp level.
// - After reset data registers and data latches return to defaults.
// - Detection with supply below threshold selects the minus ten to zero range.
// - Detection with supply above threshold selects the zero to five range.
// - Detection results per group are readable in the general status register.
// - Writes to power-down or device configuration registers re-run detection.
// - Host may write any of four ranges per group through range registers.
// - Clamp level follows the group's negative supply pin only.
// - A positive range is accepted even with a negative clamp level.
`timescale 1ns/10ps
`default_nettype none
module dgr_range_ctrl
    import dgr_pkg::*;
(
    // Clock and reset.
    input  wire logic        CLK_IN,
    input  wire logic        RST_IN,
    // Serial register interface, mode 0.
    input  wire logic        SPI_CS_N_IN,
    input  wire logic        SPI_SCLK_IN,
    input  wire logic        SPI_SDI_IN,
    output logic             SPI_SDO_OUT,
    output logic             SPI_SDO_OE_N_OUT,
    // Per-group supply comparators, high when the negative supply is below threshold.
    input  wire logic [3:0]  GRP_BELOW_TH_IN,
    // DAC analog control.
    output logic [7:0]       GROUP_RANGE_OUT,
    output logic [3:0]       CLAMP_NEG_OUT,
    output logic [15:0]      DAC_CLAMP_OUT,
    output logic             DATA_DEFAULT_OUT
);
    // ========================================================
    // Pin synchronisers.
    logic [1:0]  cs_s;
    logic [2:0]  sclk_s;
    logic [1:0]  sdi_s;
    logic [3:0]  below_a;
    logic [3:0]  below_s;

    always_ff @(posedge CLK_IN) begin
        cs_s    <= {cs_s[0], SPI_CS_N_IN};
        sclk_s  <= {sclk_s[1:0], SPI_SCLK_IN};
        sdi_s   <= {sdi_s[0], SPI_SDI_IN};
        below_a <= GRP_BELOW_TH_IN;
        below_s <= below_a;
    end

    wire sclk_rise = sclk_s[1] & ~sclk_s[2];
    wire sclk_fall = ~sclk_s[1] & sclk_s[2];

    // ========================================================
    // Register state.
    logic [7:0]  dev_cfg;
    logic [7:0]  grp_range;
    logic [15:0] pd;
    logic [3:0]  status;
    logic [1:0]  det_cnt;
    logic [3:0]  clamp_neg;
    logic        data_def;
    logic [7:0]  next_dev_cfg;
    logic [7:0]  next_grp_range;
    logic [15:0] next_pd;
    logic [3:0]  next_status;
    logic [1:0]  next_det_cnt;
    logic [3:0]  next_clamp_neg;
    logic        next_data_def;

    // ========================================================
    // Serial frame engine.
    logic [4:0]  cnt;
    logic [22:0] rx;
    logic [7:0]  tx;
    logic        sdo_oe_n;
    logic        wr_stb;
    logic [7:0]  wa;
    logic [7:0]  wd;
    logic [4:0]  next_cnt;
    logic [22:0] next_rx;
    logic [7:0]  next_tx;
    logic        next_sdo_oe_n;
    logic        next_wr_stb;
    logic [7:0]  next_wa;
    logic [7:0]  next_wd;
    logic [7:0]  rd_addr;
    logic [7:0]  rd_data;

    always_comb begin
        rd_addr = {rx[6:0], sdi_s[1]};
        unique case (rd_addr)
            ADDR_DEV_CFG:  rd_data = dev_cfg;
            ADDR_RANGE_LO: rd_data = {4'h0, grp_range[3:0]};
            ADDR_RANGE_HI: rd_data = {4'h0, grp_range[7:4]};
            ADDR_STATUS:   rd_data = {4'h0, status};
            ADDR_PD_LO:    rd_data = pd[7:0];
            ADDR_PD_HI:    rd_data = pd[15:8];
            default:       rd_data = 8'h00;
        endcase
    end

    always_comb begin
        next_cnt      = cnt;
        next_rx       = rx;
        next_tx       = tx;
        next_sdo_oe_n = sdo_oe_n;
        next_wr_stb   = 1'b0;
        next_wa       = wa;
        next_wd       = wd;
        if (cs_s[1]) begin
            next_cnt      = 5'h00;
            next_sdo_oe_n = 1'b1;
        end else begin
            next_sdo_oe_n = 1'b0;
            if (sclk_rise) begin
                next_rx  = {rx[21:0], sdi_s[1]};
                // The count stops at a full frame so that long frames never write twice.
                if (cnt != FRAME_BITS) begin
                    next_cnt = cnt + 5'h01;
                end
                if (cnt == HDR_BITS - 5'h01) begin
                    next_tx = rx[14] ? rd_data : 8'h00;
                end
                if (cnt == FRAME_BITS - 5'h01) begin
                    next_wr_stb = ~rx[22];
                    next_wa     = rx[14:7];
                    next_wd     = {rx[6:0], sdi_s[1]};
                end
            end else if (sclk_fall && cnt > HDR_BITS) begin
                next_tx = {tx[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            cnt      <= 5'h00;
            rx       <= 23'h000000;
            tx       <= 8'h00;
            sdo_oe_n <= 1'b1;
            wr_stb   <= 1'b0;
            wa       <= 8'h00;
            wd       <= 8'h00;
        end else begin
            cnt      <= next_cnt;
            rx       <= next_rx;
            tx       <= next_tx;
            sdo_oe_n <= next_sdo_oe_n;
            wr_stb   <= next_wr_stb;
            wa       <= next_wa;
            wd       <= next_wd;
        end
    end

    assign SPI_SDO_OUT      = tx[7];
    assign SPI_SDO_OE_N_OUT = sdo_oe_n;

    // ========================================================
    // Range, detection and clamp control.
    always_comb begin
        next_dev_cfg   = dev_cfg;
        next_grp_range = grp_range;
        next_pd        = pd;
        next_status    = status;
        next_det_cnt   = det_cnt;
        next_clamp_neg = below_s;
        next_data_def  = 1'b0;
        if (det_cnt != 2'h0) begin
            next_det_cnt = det_cnt - 2'h1;
        end
        // Each group is decided only by its own comparator.
        for (int g = 0; g < NUM_GROUPS; g++) begin
            if (det_cnt == 2'h1) begin
                next_status[g]         = below_s[g];
                next_grp_range[2*g +: 2] = below_s[g] ? RNG_NEG10 : RNG_POS5;
            end
        end
        // A host range write issued with detection still holds its value.
        if (wr_stb) begin
            unique case (wa)
                ADDR_DEV_CFG: begin
                    next_dev_cfg = wd;
                    next_det_cnt = DET_SETTLE;
                end
                ADDR_PD_LO: begin
                    next_pd[7:0] = wd;
                    next_det_cnt = DET_SETTLE;
                end
                ADDR_PD_HI: begin
                    next_pd[15:8] = wd;
                    next_det_cnt  = DET_SETTLE;
                end
                ADDR_RANGE_LO: next_grp_range[3:0] = wd[3:0];
                ADDR_RANGE_HI: next_grp_range[7:4] = wd[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            dev_cfg   <= CFG_RESET;
            grp_range <= RANGE_RESET;
            pd        <= PD_RESET;
            status    <= 4'h0;
            det_cnt   <= DET_SETTLE;
            clamp_neg <= 4'h0;
            data_def  <= 1'b1;
        end else begin
            dev_cfg   <= next_dev_cfg;
            grp_range <= next_grp_range;
            pd        <= next_pd;
            status    <= next_status;
            det_cnt   <= next_det_cnt;
            clamp_neg <= next_clamp_neg;
            data_def  <= next_data_def;
        end
    end

    assign GROUP_RANGE_OUT  = grp_range;
    assign CLAMP_NEG_OUT    = clamp_neg;
    assign DAC_CLAMP_OUT    = pd;
    assign DATA_DEFAULT_OUT = data_def;

    // ========================================================
    // Checks.
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    property p_det_neg;
        det_cnt == 2'h1 && below_s[0] && !(wr_stb && wa == ADDR_RANGE_LO) |=> grp_range[1:0] == RNG_NEG10;
    endproperty
    a_det_neg: assert property (p_det_neg) else $error("negative detect range wrong");

    property p_det_pos;
        det_cnt == 2'h1 && !below_s[3] && !(wr_stb && wa == ADDR_RANGE_HI) |=> grp_range[7:6] == RNG_POS5;
    endproperty
    a_det_pos: assert property (p_det_pos) else $error("positive detect range wrong");

    property p_status;
        det_cnt == 2'h1 |=> status == $past(below_s);
    endproperty
    a_status: assert property (p_status) else $error("status not loaded from detection");

    property p_retrigger;
        wr_stb && (wa == ADDR_DEV_CFG || wa == ADDR_PD_LO || wa == ADDR_PD_HI) |=> det_cnt == DET_SETTLE ##2 det_cnt == 2'h1;
    endproperty
    a_retrigger: assert property (p_retrigger) else $error("detection not re-run");

    property p_range_wr;
        wr_stb && wa == ADDR_RANGE_HI |=> grp_range[7:4] == $past(wd[3:0]);
    endproperty
    a_range_wr: assert property (p_range_wr) else $error("range write not applied");

    property p_indep;
        wr_stb && wa == ADDR_RANGE_LO && det_cnt != 2'h1 |=> $stable(grp_range[7:4]);
    endproperty
    a_indep: assert property (p_indep) else $error("other groups disturbed");

    property p_reset_clamp;
        $past(RST_IN) |-> DAC_CLAMP_OUT == PD_RESET && DATA_DEFAULT_OUT;
    endproperty
    a_reset_clamp: assert property (p_reset_clamp) else $error("reset defaults missing");

    property p_clamp_level;
        !$past(RST_IN) |-> CLAMP_NEG_OUT == $past(GRP_BELOW_TH_IN, 3);
    endproperty
    a_clamp_level: assert property (p_clamp_level) else $error("clamp level not from supply");

    property p_hold;
        det_cnt != 2'h1 |=> $stable(status);
    endproperty
    a_hold: assert property (p_hold) else $error("status changed without trigger");

    property p_data_def;
        !$past(RST_IN) |-> !DATA_DEFAULT_OUT;
    endproperty
    a_data_def: assert property (p_data_def) else $error("default pulse too long");
endmodule
`default_nettype wire
